// ### verilog/pppf_map.svh
// Overview of operation
// - Capture the pixel word on every pixel clock rising edge; palette mode uses one byte.
// - In palette mode the pixel byte is ANDed with the pixel mask.
// - In palette mode the masked byte addresses the palette word feeding three channels.
// - Direct 15/16-bit and 24-bit modes route pixel lines straight to the channels.
// - Blanking is sampled on the same pixel clock edge as the pixel word.
// - Pixel and blanking advance one stage per pixel clock: palette, DAC, output.
// - Frequency selects are latched when the select strobe falls and choose the clock.
// - While blanking is active all three colour outputs are zero.
// - DAC power-down is asserted while blanking is active and released after.
// - Host palette writes are still accepted during blanking.
// - Select codes 0 and 3 reach one shared palette index pointer.
// - Every host register can be written and read back, except code 3, which reads back the written index plus one.
// - Register select is sampled on the falling edge of the active host strobe.
// - A host write stores the data bus on the rising edge of write strobe.
// - Mode switch low picks the primary pixel mode, high the secondary one.
`ifndef PPPF_MAP_SVH
`define PPPF_MAP_SVH

`define PPPF_SEL_INDEX      3'h0
`define PPPF_SEL_COLOUR     3'h1
`define PPPF_SEL_MASK       3'h2
`define PPPF_SEL_INDEX_RD   3'h3
`define PPPF_SEL_PLL_WIDX   3'h4
`define PPPF_SEL_PLL_PARAM  3'h5
`define PPPF_SEL_CMD        3'h6
`define PPPF_SEL_PLL_RIDX   3'h7

`define PPPF_MASK_RST       8'hff
`define PPPF_CMD_RST        8'h00
`define PPPF_CMD_PRI_LSB    0
`define PPPF_CMD_SEC_LSB    2

`define PPPF_LAST_SLOT      2'h2

`endif

// ### verilog/pppf_pkg.sv
package pppf_pkg;

	typedef enum logic [1:0] {
		PPPF_PALETTE  = 2'h0,
		PPPF_DIRECT15 = 2'h1,
		PPPF_DIRECT16 = 2'h3,
		PPPF_DIRECT24 = 2'h2
	} pppf_mode_e;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} pppf_rgb_s;

endpackage

// ### verilog/pppf_pal_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pppf_pal_if;
	logic        we;
	logic [7:0]  wa;
	logic [17:0] wd;
	logic [7:0]  pix_addr;
	logic [17:0] pix_data;
	logic [7:0]  host_addr;
	logic [17:0] host_data;

	modport ram (
		input  we,
		input  wa,
		input  wd,
		input  pix_addr,
		input  host_addr,
		output pix_data,
		output host_data
	);

	modport user (
		output we,
		output wa,
		output wd,
		output pix_addr,
		output host_addr,
		input  pix_data,
		input  host_data
	);
endinterface
`default_nettype wire

// ### verilog/pppf_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pppf_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pppf_sync_s;

	pppf_sync_s st_ff;
	pppf_sync_s nxt_st;

	// Stage one feeds stage two only, so metastability never reaches logic
	always_comb begin
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
		if (srst) begin
			nxt_st.s1 = INIT;
			nxt_st.s2 = INIT;
		end
	end

	always_ff @(posedge clk_sys) begin
		st_ff <= nxt_st;
	end

	assign q = st_ff.s2;
endmodule
`default_nettype wire

// ### verilog/pppf_palette.sv
`timescale 1ns/10ps
`default_nettype none
module pppf_palette #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 18
) (
	input  wire logic clk_sys,
	pppf_pal_if.ram   pal
);
	// Contents are not reset; software loads the palette after power-up
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (pal.we) begin
			mem[pal.wa] <= pal.wd;
		end
	end

	// Separate read ports so host traffic never stalls the pixel path
	assign pal.pix_data  = mem[pal.pix_addr];
	assign pal.host_data = mem[pal.host_addr];
endmodule
`default_nettype wire

// ### verilog/pppf_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pppf_map.svh"
module pppf_top
	import pppf_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        pclk,
	input  wire logic [15:0] pixel_word_in,
	input  wire logic        blank_n,
	input  wire logic        depth_switch,
	input  wire logic        strobe_n,
	input  wire logic        freq_select_0,
	input  wire logic        freq_select_1,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [2:0]  host_reg_select,
	input  wire logic [7:0]  host_data_bus_in,
	output logic      [7:0]  host_data_bus_out,
	output logic             host_data_bus_oe_n,
	output logic      [7:0]  red_code,
	output logic      [7:0]  green_code,
	output logic      [7:0]  blue_code,
	output logic             dac_power_down,
	output logic      [1:0]  vclk_sel
);
	typedef struct packed {
		logic        pclk_d;
		logic        strobe_d;
		logic        rd_d;
		logic        wr_d;
		logic [2:0]  sel;
		logic [7:0]  ptr;
		logic [7:0]  mask;
		logic [7:0]  cmd;
		logic [7:0]  pll_idx;
		logic [7:0]  pll_param;
		logic [1:0]  cv_cnt;
		logic [17:0] cv;
		logic        ram_we;
		logic [7:0]  ram_wa;
		logic [17:0] ram_wd;
		logic [7:0]  rdata;
		logic [1:0]  vsel;
		logic [15:0] cap_word;
		logic [15:0] prev_word;
		logic        cap_blank_n;
		pppf_mode_e  cap_mode;
		pppf_rgb_s   ram_rgb;
		logic        ram_blank_n;
		pppf_rgb_s   dac_rgb;
		logic        dac_blank_n;
		pppf_rgb_s   out_rgb;
		logic        out_blank_n;
	} pppf_state_s;

	localparam int SW = 35;

	pppf_state_s st_ff;
	pppf_state_s nxt_st;
	pppf_pal_if  pal ();

	logic [SW-1:0] sync_q;
	logic          pclk_s;
	logic          blank_s;
	logic          strobe_s;
	logic [1:0]    fsel_s;
	logic          ds_s;
	logic          rd_s;
	logic          wr_s;
	logic [2:0]    sel_s;
	logic [7:0]    data_s;
	logic [15:0]   pix_s;
	logic          pclk_rise;
	logic          strobe_fall;
	logic          rd_fall;
	logic          rd_rise;
	logic          wr_fall;
	logic          wr_rise;
	logic [2:0]    sel_eff;
	pppf_mode_e    mode_now;

	pppf_sync #(
		.W    (SW),
		.INIT ({1'b0, 1'b1, 1'b1, 2'b00, 1'b0, 1'b1, 1'b1, 3'h0, 8'h00, 16'h0000})
	) u_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.d       ({pclk, blank_n, strobe_n, freq_select_1, freq_select_0, depth_switch,
		           rd_n, wr_n, host_reg_select, host_data_bus_in, pixel_word_in}),
		.q       (sync_q)
	);

	assign {pclk_s, blank_s, strobe_s, fsel_s, ds_s, rd_s, wr_s, sel_s, data_s, pix_s} = sync_q;

	pppf_palette #(
		.DEPTH (256),
		.WIDTH (18)
	) u_palette (
		.clk_sys (clk_sys),
		.pal     (pal)
	);

	assign pclk_rise   = ~st_ff.pclk_d & pclk_s;
	assign strobe_fall = st_ff.strobe_d & ~strobe_s;
	assign rd_fall     = st_ff.rd_d & ~rd_s;
	assign rd_rise     = ~st_ff.rd_d & rd_s;
	assign wr_fall     = st_ff.wr_d & ~wr_s;
	assign wr_rise     = ~st_ff.wr_d & wr_s;
	assign sel_eff     = (rd_fall | wr_fall) ? sel_s : st_ff.sel;

	// Pixel path and host path use separate palette ports
	assign pal.we        = st_ff.ram_we;
	assign pal.wa        = st_ff.ram_wa;
	assign pal.wd        = st_ff.ram_wd;
	assign pal.pix_addr  = st_ff.cap_word[7:0] & st_ff.mask;
	assign pal.host_addr = (wr_rise && st_ff.sel == `PPPF_SEL_INDEX_RD) ? data_s : st_ff.ptr;

	always_comb begin
		mode_now = pppf_mode_e'(st_ff.cmd[`PPPF_CMD_PRI_LSB +: 2]);
		if (ds_s) begin
			mode_now = pppf_mode_e'(st_ff.cmd[`PPPF_CMD_SEC_LSB +: 2]);
		end
	end

	always_comb begin
		nxt_st          = st_ff;
		nxt_st.pclk_d   = pclk_s;
		nxt_st.strobe_d = strobe_s;
		nxt_st.rd_d     = rd_s;
		nxt_st.wr_d     = wr_s;
		nxt_st.ram_we   = 1'b0;

		if (strobe_fall) begin
			nxt_st.vsel = fsel_s;
		end

		if (rd_fall || wr_fall) begin
			nxt_st.sel = sel_s;
		end

		// Host writes never look at blanking, so palette loads go on during it
		if (wr_rise) begin
			unique case (st_ff.sel)
				`PPPF_SEL_INDEX: begin
					nxt_st.ptr    = data_s;
					nxt_st.cv_cnt = 2'h0;
				end
				`PPPF_SEL_INDEX_RD: begin
					nxt_st.cv     = pal.host_data;
					nxt_st.ptr    = data_s + 8'h01;
					nxt_st.cv_cnt = 2'h0;
				end
				`PPPF_SEL_COLOUR: begin
					if (st_ff.cv_cnt == 2'h0) begin
						nxt_st.cv[17:12] = data_s[5:0];
						nxt_st.cv_cnt    = 2'h1;
					end else if (st_ff.cv_cnt == 2'h1) begin
						nxt_st.cv[11:6] = data_s[5:0];
						nxt_st.cv_cnt   = 2'h2;
					end else begin
						nxt_st.cv[5:0] = data_s[5:0];
						nxt_st.ram_we  = 1'b1;
						nxt_st.ram_wa  = st_ff.ptr;
						nxt_st.ram_wd  = {st_ff.cv[17:6], data_s[5:0]};
						nxt_st.ptr     = st_ff.ptr + 8'h01;
						nxt_st.cv_cnt  = 2'h0;
					end
				end
				`PPPF_SEL_MASK: begin
					nxt_st.mask = data_s;
				end
				`PPPF_SEL_PLL_WIDX,
				`PPPF_SEL_PLL_RIDX: begin
					nxt_st.pll_idx = data_s;
				end
				`PPPF_SEL_PLL_PARAM: begin
					nxt_st.pll_param = data_s;
				end
				`PPPF_SEL_CMD: begin
					nxt_st.cmd = data_s;
				end
			endcase
		end

		// A colour read advances on the end of each read strobe
		if (rd_rise && st_ff.sel == `PPPF_SEL_COLOUR) begin
			if (st_ff.cv_cnt >= `PPPF_LAST_SLOT) begin
				nxt_st.cv     = pal.host_data;
				nxt_st.ptr    = st_ff.ptr + 8'h01;
				nxt_st.cv_cnt = 2'h0;
			end else begin
				nxt_st.cv_cnt = st_ff.cv_cnt + 2'h1;
			end
		end

		unique case (sel_eff)
			`PPPF_SEL_INDEX,
			`PPPF_SEL_INDEX_RD:  nxt_st.rdata = st_ff.ptr;
			`PPPF_SEL_COLOUR: begin
				if (st_ff.cv_cnt == 2'h0) begin
					nxt_st.rdata = {2'b00, st_ff.cv[17:12]};
				end else if (st_ff.cv_cnt == 2'h1) begin
					nxt_st.rdata = {2'b00, st_ff.cv[11:6]};
				end else begin
					nxt_st.rdata = {2'b00, st_ff.cv[5:0]};
				end
			end
			`PPPF_SEL_MASK:      nxt_st.rdata = st_ff.mask;
			`PPPF_SEL_PLL_WIDX,
			`PPPF_SEL_PLL_RIDX:  nxt_st.rdata = st_ff.pll_idx;
			`PPPF_SEL_PLL_PARAM: nxt_st.rdata = st_ff.pll_param;
			`PPPF_SEL_CMD:       nxt_st.rdata = st_ff.cmd;
		endcase

		// Whole pixel pipeline steps together, one stage per pixel clock edge
		if (pclk_rise) begin
			nxt_st.cap_word    = pix_s;
			nxt_st.prev_word   = st_ff.cap_word;
			nxt_st.cap_blank_n = blank_s;
			nxt_st.cap_mode    = mode_now;
			unique case (st_ff.cap_mode)
				PPPF_PALETTE: begin
					nxt_st.ram_rgb.r = {pal.pix_data[17:12], 2'b00};
					nxt_st.ram_rgb.g = {pal.pix_data[11:6], 2'b00};
					nxt_st.ram_rgb.b = {pal.pix_data[5:0], 2'b00};
				end
				PPPF_DIRECT15: begin
					nxt_st.ram_rgb.r = {st_ff.cap_word[14:10], 3'b000};
					nxt_st.ram_rgb.g = {st_ff.cap_word[9:5], 3'b000};
					nxt_st.ram_rgb.b = {st_ff.cap_word[4:0], 3'b000};
				end
				PPPF_DIRECT16: begin
					nxt_st.ram_rgb.r = {st_ff.cap_word[15:11], 3'b000};
					nxt_st.ram_rgb.g = {st_ff.cap_word[10:5], 2'b00};
					nxt_st.ram_rgb.b = {st_ff.cap_word[4:0], 3'b000};
				end
				PPPF_DIRECT24: begin
					// Packed 24-bit: red and green from the earlier word, blue from this one
					nxt_st.ram_rgb.r = st_ff.prev_word[15:8];
					nxt_st.ram_rgb.g = st_ff.prev_word[7:0];
					nxt_st.ram_rgb.b = st_ff.cap_word[7:0];
				end
			endcase
			nxt_st.ram_blank_n = st_ff.cap_blank_n;
			nxt_st.dac_rgb     = st_ff.ram_blank_n ? st_ff.ram_rgb : '0;
			nxt_st.dac_blank_n = st_ff.ram_blank_n;
			nxt_st.out_rgb     = st_ff.dac_rgb;
			nxt_st.out_blank_n = st_ff.dac_blank_n;
		end

		if (srst) begin
			nxt_st          = '0;
			nxt_st.strobe_d = 1'b1;
			nxt_st.rd_d     = 1'b1;
			nxt_st.wr_d     = 1'b1;
			nxt_st.mask     = `PPPF_MASK_RST;
			nxt_st.cmd      = `PPPF_CMD_RST;
		end
	end

	always_ff @(posedge clk_sys) begin
		st_ff <= nxt_st;
	end

	assign host_data_bus_out  = st_ff.rdata;
	assign host_data_bus_oe_n = st_ff.rd_d;
	assign red_code           = st_ff.out_rgb.r;
	assign green_code         = st_ff.out_rgb.g;
	assign blue_code          = st_ff.out_rgb.b;
	assign dac_power_down     = ~st_ff.out_blank_n;
	assign vclk_sel           = st_ff.vsel;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	capture_word_a: assert property (
		pclk_rise |=> st_ff.cap_word == $past(pix_s))
		else $error("pixel word not captured on pixel clock edge");
	mask_apply_a: assert property (
		(pal.pix_addr & ~st_ff.mask) == 8'h00)
		else $error("masked-off bit reached palette address");
	palette_look_a: assert property (
		pclk_rise && st_ff.cap_mode == PPPF_PALETTE
		|=> st_ff.ram_rgb.g == {$past(pal.pix_data[11:6]), 2'b00})
		else $error("palette word did not feed colour stage");
	direct_bypass_a: assert property (
		pclk_rise && st_ff.cap_mode == PPPF_DIRECT16
		|=> st_ff.ram_rgb.r == {$past(st_ff.cap_word[15:11]), 3'b000})
		else $error("direct colour not routed from pixel word");
	blank_align_a: assert property (
		pclk_rise |=> st_ff.cap_blank_n == $past(blank_s))
		else $error("blanking not sampled with pixel word");
	pipe_step_a: assert property (
		pclk_rise |=> st_ff.ram_blank_n == $past(st_ff.cap_blank_n)
		&& st_ff.dac_blank_n == $past(st_ff.ram_blank_n)
		&& st_ff.out_blank_n == $past(st_ff.dac_blank_n))
		else $error("blanking did not advance one stage per edge");
	strobe_latch_a: assert property (
		strobe_fall |=> vclk_sel == $past(fsel_s))
		else $error("frequency select not latched on strobe");
	blank_black_a: assert property (
		pclk_rise && !st_ff.dac_blank_n
		|=> red_code == 8'h00 && green_code == 8'h00 && blue_code == 8'h00)
		else $error("colour outputs not zero in blanking");
	power_down_a: assert property (
		pclk_rise && st_ff.dac_blank_n |=> !dac_power_down)
		else $error("power-down not released after blanking");
	blank_write_a: assert property (
		wr_rise && st_ff.sel == `PPPF_SEL_COLOUR && st_ff.cv_cnt == 2'h2
		|=> pal.we && pal.wa == $past(st_ff.ptr))
		else $error("palette write lost");
	shared_ptr_a: assert property (
		rd_fall && (sel_s == `PPPF_SEL_INDEX || sel_s == `PPPF_SEL_INDEX_RD)
		|=> host_data_bus_out == $past(st_ff.ptr))
		else $error("index pointer not returned");
	sel_sample_a: assert property (
		(rd_fall || wr_fall) |=> st_ff.sel == $past(sel_s))
		else $error("register select not sampled on strobe fall");
	mask_write_a: assert property (
		wr_rise && st_ff.sel == `PPPF_SEL_MASK |=> st_ff.mask == $past(data_s))
		else $error("mask not stored on write strobe rise");
	reset_dflt_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		$past(srst) |-> st_ff.mask == `PPPF_MASK_RST && st_ff.cap_mode == PPPF_PALETTE)
		else $error("reset defaults wrong");

	cov_pixel_shown_c: cover property (pclk_rise && st_ff.dac_blank_n && st_ff.dac_rgb != '0);
	cov_colour_commit_c: cover property (st_ff.ram_we && !st_ff.out_blank_n);
	cov_strobe_c: cover property (strobe_fall);
	cov_direct_c: cover property (pclk_rise && st_ff.cap_mode == PPPF_DIRECT16);
endmodule
`default_nettype wire

// ### verification/pppf_pixel_src.sv
`timescale 1ns/10ps
`default_nettype none
module pppf_pixel_src (
	output logic        pclk,
	output logic [15:0] pixel_word_in,
	output logic        blank_n
);
	initial begin
		pclk = 1'b0;
		pixel_word_in = 16'h0000;
		blank_n = 1'b1;
	end

	// Pixel clock only runs inside a burst and stands low between bursts
	task automatic send(input logic [15:0] w, input logic b, input int n);
		for (int i = 0; i < n; i++) begin
			pixel_word_in = w;
			blank_n = b;
			#200 pclk = 1'b1;
			#200 pclk = 1'b0;
		end
		// Released word shows the inverse so a stale value cannot pass as fresh
		pixel_word_in = ~w;
	endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pppf_map.svh"
module testbench
	import pppf_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        srst;
	logic        pclk;
	logic [15:0] pixel_word_in;
	logic        blank_n;
	logic        depth_switch;
	logic        strobe_n;
	logic        freq_select_0;
	logic        freq_select_1;
	logic        rd_n;
	logic        wr_n;
	logic [2:0]  host_reg_select;
	logic [7:0]  host_data_bus_in;
	logic [7:0]  host_data_bus_out;
	logic        host_data_bus_oe_n;
	logic [7:0]  red_code;
	logic [7:0]  green_code;
	logic [7:0]  blue_code;
	logic        dac_power_down;
	logic [1:0]  vclk_sel;
	int          mismatches = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #25 clk_sys = ~clk_sys;

	pppf_pixel_src src (
		.pclk          (pclk),
		.pixel_word_in (pixel_word_in),
		.blank_n       (blank_n)
	);

	pppf_top uut (
		.clk_sys            (clk_sys),
		.srst               (srst),
		.pclk               (pclk),
		.pixel_word_in      (pixel_word_in),
		.blank_n            (blank_n),
		.depth_switch       (depth_switch),
		.strobe_n           (strobe_n),
		.freq_select_0      (freq_select_0),
		.freq_select_1      (freq_select_1),
		.rd_n               (rd_n),
		.wr_n               (wr_n),
		.host_reg_select    (host_reg_select),
		.host_data_bus_in   (host_data_bus_in),
		.host_data_bus_out  (host_data_bus_out),
		.host_data_bus_oe_n (host_data_bus_oe_n),
		.red_code           (red_code),
		.green_code         (green_code),
		.blue_code          (blue_code),
		.dac_power_down     (dac_power_down),
		.vclk_sel           (vclk_sel)
	);

	task automatic complete_run();
		$display("TB: checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Strobes are held six cycles, three times the synchroniser depth, so none is missed
	task automatic host_wr(input logic [2:0] sel, input logic [7:0] d);
		host_reg_select = sel;
		host_data_bus_in = d;
		wr_n = 1'b0;
		idle(6);
		wr_n = 1'b1;
		idle(6);
	endtask

	task automatic rd_chk(input logic [2:0] sel, input logic [7:0] exp);
		host_reg_select = sel;
		rd_n = 1'b0;
		idle(6);
		check("bus drive", {31'h0, host_data_bus_oe_n}, 32'h0);
		check("read data", {24'h0, host_data_bus_out}, {24'h0, exp});
		rd_n = 1'b1;
		idle(6);
		check("bus release", {31'h0, host_data_bus_oe_n}, 32'h1);
	endtask

	task automatic wr_rgb(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
		host_wr(`PPPF_SEL_COLOUR, r);
		host_wr(`PPPF_SEL_COLOUR, g);
		host_wr(`PPPF_SEL_COLOUR, b);
	endtask

	// Five equal pixels: packed 24 needs the word before as well, then the clock stands
	task automatic show(input logic [15:0] w, input logic b, input logic [23:0] exp);
		src.send(w, b, 5);
		idle(8);
		check("colour codes", {8'h0, red_code, green_code, blue_code}, {8'h0, exp});
		check("power down", {31'h0, dac_power_down}, {31'h0, ~b});
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		srst = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		strobe_n = 1'b1;
		depth_switch = 1'b0;
		freq_select_0 = 1'b0;
		freq_select_1 = 1'b0;
		host_reg_select = 3'h0;
		host_data_bus_in = 8'h00;
		idle(16);
		srst = 1'b0;
		idle(4);
		check("power down", {31'h0, dac_power_down}, 32'h1);
		check("colour codes", {8'h0, red_code, green_code, blue_code}, 32'h0);
		check("clock select", {30'h0, vclk_sel}, 32'h0);
		rd_chk(`PPPF_SEL_MASK, `PPPF_MASK_RST);
		rd_chk(`PPPF_SEL_CMD, `PPPF_CMD_RST);
		host_wr(`PPPF_SEL_INDEX, 8'h5a);
		rd_chk(`PPPF_SEL_INDEX, 8'h5a);
		rd_chk(`PPPF_SEL_INDEX_RD, 8'h5a);
		host_wr(`PPPF_SEL_PLL_PARAM, 8'h3c);
		rd_chk(`PPPF_SEL_PLL_PARAM, 8'h3c);
		// Entry 0 is loaded because the reset pixel word looks it up on the first edge
		host_wr(`PPPF_SEL_INDEX, 8'h00);
		wr_rgb(8'h15, 8'h2a, 8'h3f);
		host_wr(`PPPF_SEL_INDEX, 8'h05);
		wr_rgb(8'h3f, 8'h01, 8'h2a);
		rd_chk(`PPPF_SEL_INDEX, 8'h06);
		host_wr(`PPPF_SEL_MASK, 8'h0f);
		rd_chk(`PPPF_SEL_MASK, 8'h0f);
		// Unmasked index 35 holds no written entry, so a missing mask shows
		show(16'hab35, 1'b1, 24'hfc04a8);
		show(16'h0005, 1'b0, 24'h000000);
		// Palette traffic while the screen is blanked
		host_wr(`PPPF_SEL_INDEX, 8'h07);
		wr_rgb(8'h11, 8'h22, 8'h33);
		host_wr(`PPPF_SEL_INDEX_RD, 8'h07);
		rd_chk(`PPPF_SEL_COLOUR, 8'h11);
		rd_chk(`PPPF_SEL_COLOUR, 8'h22);
		rd_chk(`PPPF_SEL_COLOUR, 8'h33);
		rd_chk(`PPPF_SEL_INDEX, 8'h09);
		host_wr(`PPPF_SEL_CMD, {4'h0, PPPF_DIRECT24, PPPF_PALETTE});
		depth_switch = 1'b1;
		show(16'h9c4e, 1'b1, 24'h9c4e4e);
		depth_switch = 1'b0;
		show(16'hff07, 1'b1, 24'h4488cc);
		host_wr(`PPPF_SEL_CMD, {4'h0, PPPF_DIRECT15, PPPF_DIRECT16});
		show(16'h9c8a, 1'b1, 24'h989050);
		depth_switch = 1'b1;
		show(16'h9c8a, 1'b1, 24'h382050);
		depth_switch = 1'b0;
		freq_select_1 = 1'b1;
		freq_select_0 = 1'b0;
		idle(4);
		strobe_n = 1'b0;
		idle(6);
		strobe_n = 1'b1;
		idle(6);
		// Selects move without a strobe and must not be taken
		freq_select_1 = 1'b0;
		freq_select_0 = 1'b1;
		idle(6);
		check("clock select", {30'h0, vclk_sel}, 32'h2);
		complete_run();
	end
endmodule
`default_nettype wire
